// File: hw/encoder_signal_monitor.sv
// How it works
// RQ1: Gain loop regulates amplitude 60 to 120 percent
// RQ2: Offset loop corrects within ten percent nominal
// RQ3: Static phase trim with forty steps
// RQ4: One bit selects five or ten degree span
// RQ5: Start values fetched from EEPROM after reset
// RQ6: No EEPROM gives midpoint start values
// RQ7: Offset range 25 percent, gain 56..168
// RQ8: Vector below 30 percent raises fault
// RQ9: Nine sources, each gated by mask bit; code has six mask bits, each sin/cos pair shares one
// RQ10: Per-source latch enable stores or follows; code has six latch bits, each sin/cos pair shares one
// RQ11: Error pin is OR of enabled flags
// RQ12: Error pulse lasts at least eight cycles
// RQ13: Error pin open drain, pulls low only
// RQ14: Hold bit freezes A/B/Z during error
// RQ15: Error lasts at least one edge interval
// RQ16: Latched flag kept until reset or command
// RQ17: Host discards results, re-passes reference mark
// RQ18: Vector fault has mask, latch, status bit
// RQ19: Converter overdrive flags share mask and latch
// RQ20: Offset and gain limits flag per channel
// RQ21: Speed threshold depends on selected mode
// RQ22: Quadrature fault also on rate change
// RQ23: Edge interval one to 128 clock periods
// RQ24: Host sets quadrature mode for both outputs
// RQ25: Counter-reset clears all stored flags at once
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "esc_params.svh"
module encoder_signal_monitor import esc_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [15:0] wrData,
   input wire logic wrStb,
   input wire logic rdStb,
   output logic [15:0] rdData,
   input wire logic [11:0] ampSin,
   input wire logic [11:0] ampCos,
   input wire logic signed [11:0] offMeasSin,
   input wire logic signed [11:0] offMeasCos,
   input wire logic [11:0] vectorMag,
   input wire logic adcOverSin,
   input wire logic adcOverCos,
   input wire logic overspeedQuad,
   input wire logic overspeedCount,
   input wire logic quadTooFast,
   input wire logic counterResetCmd,
   input wire logic quadAIn,
   input wire logic quadBIn,
   input wire logic quadZIn,
   input wire logic eePresent,
   input wire logic eeAck,
   input wire logic [15:0] eeData,
   input wire logic errorOutNIn,
   output logic eeReq,
   output logic [1:0] eeAddr,
   output logic quadA,
   output logic quadB,
   output logic quadZ,
   output logic errorOutN,
   output logic errorOutNOe,
   output logic [10:0] gainSin,
   output logic [10:0] gainCos,
   output logic signed [11:0] offSin,
   output logic signed [11:0] offCos,
   output logic [5:0] phaseTrim,
   output logic phaseWide,
   output logic [3:0] irate,
   output logic [2:0] tppCode
);
   localparam int LOOP_TICKS = `LOOP_TICK_NS / (1000000000 / `CLK_HZ);

   // ==========================================
   // Helper functions
   function automatic logic [10:0] gainStep(input logic [10:0] cur, input logic [11:0] amp);
      logic [10:0] nxt;
      nxt = cur;
      if (amp < `AMP_NOM && cur < `GAIN_MAX) begin
         nxt = cur + 11'h001;
      end else if (amp > `AMP_NOM && cur > `GAIN_MIN) begin
         nxt = cur - 11'h001;
      end
      return nxt;
   endfunction : gainStep

   function automatic logic [11:0] offStep(input logic [11:0] cur, input logic [11:0] meas);
      logic [11:0] nxt;
      nxt = cur;
      if ($signed(meas) > 0 && $signed(cur) > -$signed(`OFF_LIM)) begin
         nxt = cur - 12'h001;
      end else if ($signed(meas) < 0 && $signed(cur) < $signed(`OFF_LIM)) begin
         nxt = cur + 12'h001;
      end
      return nxt;
   endfunction : offStep

   function automatic logic gainAtLimit(input logic [10:0] g);
      return (g <= `GAIN_MIN) || (g >= `GAIN_MAX);
   endfunction : gainAtLimit

   function automatic logic offAtLimit(input logic [11:0] o);
      return ($signed(o) <= -$signed(`OFF_LIM)) || ($signed(o) >= $signed(`OFF_LIM));
   endfunction : offAtLimit

   // Widen six group bits to nine per-flag bits
   function automatic fault_vec_t spread(input logic [5:0] g);
      return {g[5], g[4], g[3], g[3], g[2], g[2], g[1], g[1], g[0]};
   endfunction : spread

   // ==========================================
   // Submodules
   esc_core_if lk ();

   start_value_loader uLoader (
      .clk(clk),
      .rst(rst),
      .eePresent(eePresent),
      .eeAck(eeAck),
      .eeData(eeData),
      .eeReq(eeReq),
      .eeAddr(eeAddr),
      .lk(lk.loader)
   );

   error_pulse_stretch uStretch (
      .clk(clk),
      .rst(rst),
      .lk(lk.stretch)
   );

   // ==========================================
   // Register state
   logic [15:0] cfg_r;
   fault_vec_t flags_r;
   fault_vec_t flags_nxt;
   logic [7:0] loopCnt_r;
   logic loopTick;
   logic rateChg_r;
   logic [7:0] gapCnt_r;

   wire wrCfg = wrStb && (addr == `ADDR_CFG);
   wire wrGainSin = wrStb && (addr == `ADDR_GAIN_SIN);
   wire wrGainCos = wrStb && (addr == `ADDR_GAIN_COS);
   wire wrOffSin = wrStb && (addr == `ADDR_OFF_SIN);
   wire wrOffCos = wrStb && (addr == `ADDR_OFF_COS);
   wire wrPhase = wrStb && (addr == `ADDR_PHASE);
   wire wrRate = wrStb && (addr == `ADDR_RATE);

   wire [5:0] maskGrp = cfg_r[`CFG_MASK_LSB +: 6];
   wire [5:0] latchGrp = cfg_r[`CFG_LATCH_LSB +: 6];
   wire quadMode = cfg_r[`CFG_QUAD_MODE_BIT];
   wire holdOnFault = cfg_r[`CFG_HOLD_BIT];

   // ==========================================
   // Configuration and rate registers
   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_r <= `CFG_RESET;
         phaseTrim <= `PHASE_RESET;
         phaseWide <= 1'b0;
         irate <= 4'h0;
         tppCode <= 3'h0;
         rateChg_r <= 1'b0;
      end else begin
         rateChg_r <= 1'b0;
         if (wrCfg) begin
            cfg_r <= wrData;
            // RQ4 span select bit
            phaseWide <= wrData[`CFG_PHASE_WIDE_BIT];
         end
         // RQ3 forty step trim
         if (wrPhase) begin
            phaseTrim <= (wrData[5:0] >= `PHASE_STEPS) ? `PHASE_STEPS - 6'h01 : wrData[5:0];
         end
         if (wrRate) begin
            irate <= wrData[`RATE_IRATE_LSB +: 4];
            tppCode <= wrData[`RATE_TPP_LSB +: 3];
            // RQ22 rate change fault
            rateChg_r <= (wrData[`RATE_IRATE_LSB +: 4] != irate) ||
                         (wrData[`RATE_TPP_LSB +: 3] != tppCode);
         end
      end
   end

   // ==========================================
   // Control loop tick
   assign loopTick = (loopCnt_r == 8'(LOOP_TICKS - 1));

   always_ff @(posedge clk) begin
      if (rst || loopTick) begin
         loopCnt_r <= 8'h00;
      end else begin
         loopCnt_r <= loopCnt_r + 8'h01;
      end
   end

   // ==========================================
   // Gain and offset correction
   wire runLoop = lk.ldDone && loopTick;

   always_ff @(posedge clk) begin
      if (rst) begin
         // RQ6 midpoint start values
         gainSin <= `GAIN_MID;
         gainCos <= `GAIN_MID;
         offSin <= `OFF_MID;
         offCos <= `OFF_MID;
      end else if (lk.ldValid) begin
         // RQ5 EEPROM start values
         unique case (lk.ldIdx)
            2'h0: gainSin <= lk.ldWord[10:0];
            2'h1: gainCos <= lk.ldWord[10:0];
            2'h2: offSin <= lk.ldWord[11:0];
            2'h3: offCos <= lk.ldWord[11:0];
         endcase
      end else begin
         // RQ1 amplitude loop
         if (wrGainSin) begin
            gainSin <= wrData[10:0];
         end else if (runLoop) begin
            gainSin <= gainStep(gainSin, ampSin);
         end
         if (wrGainCos) begin
            gainCos <= wrData[10:0];
         end else if (runLoop) begin
            gainCos <= gainStep(gainCos, ampCos);
         end
         // RQ2 offset loop
         if (wrOffSin) begin
            offSin <= wrData[11:0];
         end else if (runLoop) begin
            offSin <= offStep(offSin, offMeasSin);
         end
         if (wrOffCos) begin
            offCos <= wrData[11:0];
         end else if (runLoop) begin
            offCos <= offStep(offCos, offMeasCos);
         end
      end
   end

   // ==========================================
   // Fault sources
   fault_vec_t rawFault;
   // RQ7 setting range limits
   wire sinGainLim = gainAtLimit(gainSin);
   wire cosGainLim = gainAtLimit(gainCos);
   wire sinOffLim = offAtLimit(offSin);
   wire cosOffLim = offAtLimit(offCos);
   // RQ21 mode picks threshold
   wire speedFault = quadMode ? overspeedQuad : overspeedCount;

   // RQ8 vector below limit
   assign rawFault[SRC_VECTOR] = vectorMag < `VEC_MIN;
   // RQ19 converter overdrive
   assign rawFault[SRC_SIN_ADC] = adcOverSin;
   assign rawFault[SRC_COS_ADC] = adcOverCos;
   // RQ20 controller at limit
   assign rawFault[SRC_SIN_OFF] = sinOffLim;
   assign rawFault[SRC_COS_OFF] = cosOffLim;
   assign rawFault[SRC_SIN_GAIN] = sinGainLim;
   assign rawFault[SRC_COS_GAIN] = cosGainLim;
   assign rawFault[SRC_SPEED] = speedFault;
   // RQ22 overspeed or rate change
   assign rawFault[SRC_QUAD] = quadTooFast || rateChg_r;

   // ==========================================
   // Fault flags
   wire fault_vec_t latchEn = spread(latchGrp);
   wire fault_vec_t maskEn = spread(maskGrp);

   // RQ10 RQ16 RQ25 store or follow, set wins
   assign flags_nxt = rawFault | (flags_r & latchEn & {9{~counterResetCmd}});

   always_ff @(posedge clk) begin
      if (rst) begin
         flags_r <= 9'h000;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // RQ9 RQ11 RQ18 masked OR of flags
   assign lk.errRaw = |(flags_r & maskEn);
   assign lk.tppCode = tppCode;

   // ==========================================
   // Open-drain error pin
   always_ff @(posedge clk) begin
      if (rst) begin
         errorOutN <= 1'b1;
         errorOutNOe <= 1'b0;
      end else begin
         // RQ13 drive low only
         errorOutN <= 1'b0;
         // RQ12 RQ15 stretched error
         errorOutNOe <= lk.errActive;
      end
   end

   // ==========================================
   // Quadrature outputs with edge spacing
   wire freeze = holdOnFault && lk.errActive;
   wire outDiff = (quadAIn != quadA) || (quadBIn != quadB) || (quadZIn != quadZ);
   wire [7:0] gapLen = (8'h01 << tppCode) - 8'h01;

   always_ff @(posedge clk) begin
      if (rst) begin
         quadA <= 1'b0;
         quadB <= 1'b0;
         quadZ <= 1'b0;
         gapCnt_r <= 8'h00;
      end else if (gapCnt_r != 8'h00) begin
         gapCnt_r <= gapCnt_r - 8'h01;
      // RQ14 hold during error
      end else if (outDiff && !freeze) begin
         // RQ23 edge interval delay
         quadA <= quadAIn;
         quadB <= quadBIn;
         quadZ <= quadZIn;
         gapCnt_r <= gapLen;
      end
   end

   // ==========================================
   // Register read
   logic [15:0] readMux;
   always_comb begin
      unique case (addr)
         `ADDR_CFG: readMux = cfg_r;
         `ADDR_STAT: readMux = {7'h00, flags_r};
         `ADDR_GAIN_SIN: readMux = {5'h00, gainSin};
         `ADDR_GAIN_COS: readMux = {5'h00, gainCos};
         `ADDR_OFF_SIN: readMux = {{4{offSin[11]}}, offSin};
         `ADDR_OFF_COS: readMux = {{4{offCos[11]}}, offCos};
         `ADDR_PHASE: readMux = {10'h000, phaseTrim};
         `ADDR_RATE: readMux = {8'h00, irate, 1'b0, tppCode};
         `ADDR_INFO: readMux = {12'h000, ~errorOutNIn, lk.errActive, lk.eeFound, lk.ldDone};
         default: readMux = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdData <= 16'h0000;
      end else begin
         rdData <= rdStb ? readMux : 16'h0000;
      end
   end
endmodule : encoder_signal_monitor

// File: hw/esc_params.svh
`ifndef ESC_PARAMS_SVH
`define ESC_PARAMS_SVH

// ==========================================
// Register offsets (word index on the plain port)
`define ADDR_CFG 4'h0
`define ADDR_STAT 4'h1
`define ADDR_GAIN_SIN 4'h2
`define ADDR_GAIN_COS 4'h3
`define ADDR_OFF_SIN 4'h4
`define ADDR_OFF_COS 4'h5
`define ADDR_PHASE 4'h6
`define ADDR_RATE 4'h7
`define ADDR_INFO 4'h8

// ==========================================
// Configuration field positions
`define CFG_MASK_LSB 0
`define CFG_QUAD_MODE_BIT 5
`define CFG_LATCH_LSB 8
`define CFG_HOLD_BIT 14
`define CFG_PHASE_WIDE_BIT 15
`define RATE_TPP_LSB 0
`define RATE_IRATE_LSB 4

// ==========================================
// Reset values
`define CFG_RESET 16'h003f
`define RATE_RESET 8'h00
`define PHASE_RESET 6'h14

// ==========================================
// Correction ranges, units of 0.1 % of nominal amplitude
`define AMP_NOM 12'h3e8
`define GAIN_MIN 11'h230
`define GAIN_MAX 11'h690
`define GAIN_MID 11'h460
`define OFF_LIM 12'h0fa
`define OFF_MID 12'h000
`define VEC_MIN 12'h12c
`define AMP_GUAR_LO 12'h258
`define AMP_GUAR_HI 12'h4b0
`define OFF_GUAR 12'h064
`define PHASE_STEPS 6'h28

// ==========================================
// Timing
`define CLK_HZ 25000000
`define LOOP_TICK_NS 10240
`define ERR_MIN_CYCLES 8'h08

`endif

// File: hw/esc_pkg.sv
package esc_pkg;

   typedef enum logic [1:0] {LD_IDLE, LD_REQ, LD_WAIT, LD_DONE} load_state_e;

   typedef enum logic [3:0] {
      SRC_VECTOR, SRC_SIN_ADC, SRC_COS_ADC, SRC_SIN_OFF, SRC_COS_OFF,
      SRC_SIN_GAIN, SRC_COS_GAIN, SRC_SPEED, SRC_QUAD
   } fault_src_e;

   typedef logic [8:0] fault_vec_t;

endpackage : esc_pkg

// File: hw/esc_core_if.sv
`timescale 1ns/1ps
interface esc_core_if;
   logic ldValid;
   logic [1:0] ldIdx;
   logic [15:0] ldWord;
   logic ldDone;
   logic eeFound;
   logic errRaw;
   logic [2:0] tppCode;
   logic errActive;

   modport loader (output ldValid, ldIdx, ldWord, ldDone, eeFound);
   modport stretch (input errRaw, tppCode, output errActive);
   modport core (input ldValid, ldIdx, ldWord, ldDone, eeFound, errActive,
                 output errRaw, tppCode);
endinterface : esc_core_if

// File: hw/start_value_loader.sv
`timescale 1ns/1ps
`include "esc_params.svh"
module start_value_loader import esc_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic eePresent,
   input wire logic eeAck,
   input wire logic [15:0] eeData,
   output logic eeReq,
   output logic [1:0] eeAddr,
   esc_core_if.loader lk
);
   load_state_e state_r;
   logic [1:0] idx_r;

   // ==========================================
   // Fetch four start words after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= LD_IDLE;
         idx_r <= 2'h0;
         eeReq <= 1'b0;
         eeAddr <= 2'h0;
         lk.ldValid <= 1'b0;
         lk.ldIdx <= 2'h0;
         lk.ldWord <= 16'h0000;
         lk.ldDone <= 1'b0;
         lk.eeFound <= 1'b0;
      end else begin
         lk.ldValid <= 1'b0;
         unique case (state_r)
            LD_IDLE: begin
               lk.eeFound <= eePresent;
               if (eePresent) begin
                  state_r <= LD_REQ;
               end else begin
                  state_r <= LD_DONE;
                  lk.ldDone <= 1'b1;
               end
            end
            LD_REQ: begin
               eeReq <= 1'b1;
               eeAddr <= idx_r;
               state_r <= LD_WAIT;
            end
            LD_WAIT: begin
               if (eeAck) begin
                  eeReq <= 1'b0;
                  lk.ldValid <= 1'b1;
                  lk.ldIdx <= idx_r;
                  lk.ldWord <= eeData;
                  idx_r <= idx_r + 2'h1;
                  if (idx_r == 2'h3) begin
                     state_r <= LD_DONE;
                     lk.ldDone <= 1'b1;
                  end else begin
                     state_r <= LD_REQ;
                  end
               end
            end
            LD_DONE: begin
               lk.ldDone <= 1'b1;
            end
         endcase
      end
   end
endmodule : start_value_loader

// File: hw/error_pulse_stretch.sv
`timescale 1ns/1ps
`include "esc_params.svh"
module error_pulse_stretch import esc_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   esc_core_if.stretch lk
);
   logic [7:0] cnt_r;
   logic [7:0] tppCycles;
   logic [7:0] holdLen;

   // ==========================================
   // Longer of eight cycles and one edge interval
   assign tppCycles = 8'h01 << lk.tppCode;
   assign holdLen = (tppCycles > `ERR_MIN_CYCLES) ? tppCycles : `ERR_MIN_CYCLES;

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= 8'h00;
         lk.errActive <= 1'b0;
      end else if (lk.errRaw) begin
         cnt_r <= holdLen - 8'h01;
         lk.errActive <= 1'b1;
      end else if (cnt_r != 8'h00) begin
         cnt_r <= cnt_r - 8'h01;
      end else begin
         lk.errActive <= 1'b0;
      end
   end
endmodule : error_pulse_stretch

// File: sim/esc_chk.sv
`timescale 1ns/1ps
`include "esc_params.svh"
module esc_chk import esc_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] addr,
   input wire logic [15:0] wrData,
   input wire logic wrStb,
   input wire logic adcOverSin,
   input wire logic quadA,
   input wire logic quadB,
   input wire logic quadZ,
   input wire logic errorOutN,
   input wire logic errorOutNOe,
   input wire logic [10:0] gainSin,
   input wire logic [10:0] gainCos,
   input wire logic signed [11:0] offSin,
   input wire logic signed [11:0] offCos,
   input wire logic [5:0] phaseTrim,
   input wire logic [2:0] tppCode
);
   // ==========================================
   // Shadow of the configuration word and run counters
   logic [15:0] cfgShadow_r;
   logic [7:0] gapCnt_r;
   logic [7:0] hiCnt_r;
   logic [7:0] quietCnt_r;
   wire logic [2:0] quadOut;
   assign quadOut = {quadA, quadB, quadZ};

   always_ff @(posedge clk) begin
      if (rst) begin
         cfgShadow_r <= `CFG_RESET;
         gapCnt_r <= 8'hff;
         hiCnt_r <= 8'h00;
         quietCnt_r <= 8'h00;
      end else begin
         if (wrStb && addr == `ADDR_CFG) cfgShadow_r <= wrData;
         gapCnt_r <= $changed(quadOut) ? 8'h01 : gapCnt_r + {7'h0, gapCnt_r != 8'hff};
         hiCnt_r <= errorOutNOe ? hiCnt_r + {7'h0, hiCnt_r != 8'hff} : 8'h00;
         quietCnt_r <= (cfgShadow_r[5:0] == 6'h00) ? quietCnt_r + {7'h0, quietCnt_r != 8'hff}
                                                  : 8'h00;
      end
   end

   // ==========================================
   // Properties
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_pulse_min_len:
      assert property ($rose(errorOutNOe) |-> errorOutNOe [*8])
      else $error("error pin released before eight cycles");
   a_stretch_edge_gap:
      assert property ($fell(errorOutNOe) && $stable(tppCode) |-> hiCnt_r >= (8'h01 << tppCode))
      else $error("error pin shorter than edge interval");
   a_open_drain_low:
      assert property (errorOutNOe |-> !errorOutN)
      else $error("error pin driven high");
   a_phase_steps:
      assert property (phaseTrim < `PHASE_STEPS)
      else $error("phase trim past last step");
   a_gain_span:
      assert property (gainSin >= `GAIN_MIN && gainSin <= `GAIN_MAX
                       && gainCos >= `GAIN_MIN && gainCos <= `GAIN_MAX)
      else $error("gain outside setting range");
   a_offset_span:
      assert property (offSin >= -12'sd250 && offSin <= 12'sd250
                       && offCos >= -12'sd250 && offCos <= 12'sd250)
      else $error("offset outside setting range");
   a_edge_spacing:
      assert property ($changed(quadOut) && $stable(tppCode) |-> gapCnt_r >= (8'h01 << tppCode))
      else $error("quadrature edges too close");
   a_hold_freeze:
      assert property (cfgShadow_r[14] && errorOutNOe && $past(errorOutNOe) |-> $stable(quadOut))
      else $error("quadrature outputs moved during held error");
   a_fault_to_pin:
      assert property (cfgShadow_r[1] && $rose(adcOverSin) |-> ##3 errorOutNOe)
      else $error("enabled converter fault missing on pin");
   a_masked_quiet:
      assert property (quietCnt_r >= 8'h90 |-> !errorOutNOe)
      else $error("pin low with all sources masked");
endmodule : esc_chk

bind encoder_signal_monitor esc_chk chk_u (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
   .wrStb(wrStb), .adcOverSin(adcOverSin), .quadA(quadA), .quadB(quadB), .quadZ(quadZ),
   .errorOutN(errorOutN), .errorOutNOe(errorOutNOe), .gainSin(gainSin), .gainCos(gainCos),
   .offSin(offSin), .offCos(offCos), .phaseTrim(phaseTrim), .tppCode(tppCode));

// File: sim/ee_model.sv
`timescale 1ns/1ps
module ee_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic present,
   input wire logic slow,
   input wire logic eeReq,
   input wire logic [1:0] eeAddr,
   output logic eePresent,
   output logic eeAck,
   output logic [15:0] eeData
);
   // ==========================================
   // Serial start-value store, prompt or slow
   logic [2:0] waitCnt_r;
   wire logic [15:0] word;
   assign eePresent = present;
   assign word = (eeAddr == 2'h0) ? 16'h0230 : (eeAddr == 2'h1) ? 16'h0500 :
                 (eeAddr == 2'h2) ? 16'h00fa : 16'hfffb;

   always_ff @(posedge clk) begin
      if (rst || !eeReq || eeAck) begin
         waitCnt_r <= 3'h0;
         eeAck <= 1'b0;
         eeData <= rst ? 16'h5a5a : ~eeData;
      end else if (waitCnt_r >= (slow ? 3'h5 : 3'h0)) begin
         eeAck <= 1'b1;
         eeData <= word;
      end else begin
         waitCnt_r <= waitCnt_r + 3'h1;
         eeData <= ~eeData;
      end
   end
endmodule : ee_model

// File: sim/testbench.sv
`timescale 1ns/1ps
`include "esc_params.svh"
module testbench import esc_pkg::*;;
   logic clk, rst, wrStb, rdStb, present, slow, eePresent, eeAck, eeReq, errorOutNIn;
   logic adcOverSin, adcOverCos, overspeedQuad, overspeedCount, quadTooFast, counterResetCmd;
   logic quadAIn, quadBIn, quadZIn, quadA, quadB, quadZ, errorOutN, errorOutNOe, phaseWide;
   logic [3:0] addr, irate;
   logic [15:0] wrData, rdData, rv, eeData;
   logic [11:0] ampSin, ampCos, vectorMag;
   logic signed [11:0] offMeasSin, offMeasCos, offSin, offCos;
   logic [1:0] eeAddr;
   logic [10:0] gainSin, gainCos;
   logic [5:0] phaseTrim;
   logic [2:0] tppCode;
   logic [15:0] srcBit [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0080, 16'h0100};
   int errors, checksDone, cyc, run;

   // Wired error line with pull-up
   assign errorOutNIn = errorOutNOe ? errorOutN : 1'b1;

   encoder_signal_monitor dut_u (.clk(clk), .rst(rst), .addr(addr), .wrData(wrData),
      .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .ampSin(ampSin), .ampCos(ampCos),
      .offMeasSin(offMeasSin), .offMeasCos(offMeasCos), .vectorMag(vectorMag),
      .adcOverSin(adcOverSin), .adcOverCos(adcOverCos), .overspeedQuad(overspeedQuad),
      .overspeedCount(overspeedCount), .quadTooFast(quadTooFast),
      .counterResetCmd(counterResetCmd), .quadAIn(quadAIn), .quadBIn(quadBIn),
      .quadZIn(quadZIn), .eePresent(eePresent), .eeAck(eeAck), .eeData(eeData),
      .errorOutNIn(errorOutNIn), .eeReq(eeReq), .eeAddr(eeAddr), .quadA(quadA), .quadB(quadB),
      .quadZ(quadZ), .errorOutN(errorOutN), .errorOutNOe(errorOutNOe), .gainSin(gainSin),
      .gainCos(gainCos), .offSin(offSin), .offCos(offCos), .phaseTrim(phaseTrim),
      .phaseWide(phaseWide), .irate(irate), .tppCode(tppCode));
   ee_model ee_u (.clk(clk), .rst(rst), .present(present), .slow(slow), .eeReq(eeReq),
      .eeAddr(eeAddr), .eePresent(eePresent), .eeAck(eeAck), .eeData(eeData));

   // ==========================================
   // Bus and check tasks
   task automatic testDone;
      if (errors == 0 && checksDone > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : testDone
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checksDone++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      @(posedge clk) v = rdData;
   endtask : rd
   task automatic rdChk(input logic [3:0] a, input logic [15:0] exp);
      logic [15:0] v;
      rd(a, v);
      chk(v, exp);
   endtask : rdChk
   task automatic pulse(input logic cmd);
      @(posedge clk);
      {counterResetCmd, adcOverSin} <= cmd ? 2'b10 : 2'b01;
      @(posedge clk);
      {counterResetCmd, adcOverSin} <= 2'b00;
   endtask : pulse
   task automatic rstDut(input logic p, input logic s);
      @(posedge clk);
      rst <= 1'b1;
      present <= p;
      slow <= s;
      tick(5);
      rst <= 1'b0;
      for (int k = 0; k < 60; k++) begin
         rd(`ADDR_INFO, rv);
         if (rv[0] === 1'b1) break;
      end
   endtask : rstDut
   task automatic setSrc(input int i, input logic v);
      case (i)
         0: vectorMag <= v ? 12'd299 : 12'd1000;
         1: adcOverSin <= v;
         2: adcOverCos <= v;
         3: overspeedQuad <= v;
         default: quadTooFast <= v;
      endcase
   endtask : setSrc

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         testDone();
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      {rst, wrStb, rdStb, present, slow, adcOverSin, adcOverCos, overspeedQuad} = 8'h80;
      {overspeedCount, quadTooFast, counterResetCmd, quadAIn, quadBIn, quadZIn} = '0;
      {addr, wrData, offMeasSin, offMeasCos, errors, checksDone, cyc} = '0;
      {ampSin, ampCos, vectorMag} = {3{12'd1000}};
      rstDut(1'b0, 1'b0);
      rdChk(`ADDR_INFO, 16'h0001);
      rdChk(`ADDR_GAIN_SIN, 16'h0460);
      rdChk(`ADDR_GAIN_COS, 16'h0460);
      rdChk(`ADDR_OFF_SIN, 16'h0000);
      rdChk(`ADDR_OFF_COS, 16'h0000);
      rdChk(`ADDR_CFG, 16'h003f);
      rstDut(1'b1, 1'b1);
      rdChk(`ADDR_STAT, 16'h0028);
      rdChk(`ADDR_INFO, 16'h000f);
      rdChk(`ADDR_GAIN_SIN, 16'h0230);
      rdChk(`ADDR_GAIN_COS, 16'h0500);
      rdChk(`ADDR_OFF_SIN, 16'h00fa);
      rdChk(`ADDR_OFF_COS, 16'hfffb);
      rstDut(1'b0, 1'b0);
      wr(`ADDR_PHASE, 16'h0027);
      rdChk(`ADDR_PHASE, 16'h0027);
      wr(`ADDR_PHASE, 16'h0028);
      rdChk(`ADDR_PHASE, 16'h0027);
      wr(`ADDR_CFG, 16'h803f);
      wr(`ADDR_STAT, 16'hffff);
      chk({15'h0, phaseWide}, 16'h0001);
      rdChk(`ADDR_STAT, 16'h0000);
      rdChk(4'hf, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         setSrc(i, 1'b1);
         tick(3);
         rdChk(`ADDR_STAT, srcBit[i]);
         setSrc(i, 1'b0);
         tick(3);
         rdChk(`ADDR_STAT, 16'h0000);
      end
      vectorMag <= 12'd300;
      tick(3);
      rdChk(`ADDR_STAT, 16'h0000);
      wr(`ADDR_CFG, 16'h001f);
      overspeedQuad <= 1'b1;
      tick(3);
      rdChk(`ADDR_STAT, 16'h0000);
      overspeedQuad <= 1'b0;
      overspeedCount <= 1'b1;
      tick(3);
      rdChk(`ADDR_STAT, 16'h0080);
      overspeedCount <= 1'b0;
      wr(`ADDR_CFG, 16'h0000);
      tick(150);
      adcOverSin <= 1'b1;
      run = 0;
      repeat (12) @(posedge clk) #1 run += (errorOutNOe !== 1'b0);
      chk(run[15:0], 16'h0000);
      rdChk(`ADDR_STAT, 16'h0002);
      adcOverSin <= 1'b0;
      wr(`ADDR_CFG, 16'h023f);
      pulse(1'b0);
      tick(20);
      rdChk(`ADDR_STAT, 16'h0002);
      pulse(1'b1);
      rdChk(`ADDR_STAT, 16'h0000);
      adcOverCos <= 1'b1;
      pulse(1'b1);
      rdChk(`ADDR_STAT, 16'h0004);
      adcOverCos <= 1'b0;
      wr(`ADDR_CFG, 16'h003f);
      // Host keeps quadrature mode set while both outputs are in use
      wr(`ADDR_RATE, 16'h0003);
      tick(40);
      quadBIn <= 1'b1;
      tick(1);
      quadZIn <= 1'b1;
      tick(4);
      chk({14'h0, quadB, quadZ}, 16'h0002);
      tick(12);
      chk({14'h0, quadB, quadZ}, 16'h0003);
      wr(`ADDR_CFG, 16'h403f);
      vectorMag <= 12'd100;
      tick(6);
      quadAIn <= 1'b1;
      tick(12);
      chk({15'h0, quadA}, 16'h0000);
      vectorMag <= 12'd1000;
      tick(60);
      chk({15'h0, quadA}, 16'h0001);
      wr(`ADDR_CFG, 16'h203f);
      wr(`ADDR_RATE, 16'h0015);
      tick(3);
      rdChk(`ADDR_STAT, 16'h0100);
      pulse(1'b1);
      wr(`ADDR_RATE, 16'h0015);
      rdChk(`ADDR_RATE, 16'h0015);
      rdChk(`ADDR_STAT, 16'h0000);
      tick(60);
      pulse(1'b0);
      for (int k = 0; k < 10 && errorOutNOe !== 1'b1; k++) @(posedge clk) #1;
      run = 0;
      while (errorOutNOe === 1'b1 && run < 300) @(posedge clk) #1 run++;
      chk({15'h0, run >= 32}, 16'h0001);
      testDone();
   end
endmodule : testbench
